// ### hdl/gpio_func_consts.vh
`ifndef GPIO_FUNC_CONSTS_VH
`define GPIO_FUNC_CONSTS_VH

// Per-pin function codes, four bits each.
`define FN_HIZ        4'h0
`define FN_DRIVE1     4'h1
`define FN_DRIVE0     4'h2
`define FN_POWER_N    4'h3
`define FN_TX_LED_N   4'h4
`define FN_RX_LED_N   4'h5
`define FN_ANY_LED_N  4'h6
`define FN_CHG_BIT0   4'h7
`define FN_CHG_BIT1   4'h8
`define FN_VBUS_SENSE 4'h9
`define FN_TOUCH_IN   4'ha
`define FN_TOUCH_OUT  4'hb
`define FN_W          4

// Charger states used as index into the code map.
`define CHG_UNCONF    2'h0
`define CHG_SDP       2'h1
`define CHG_CDP_DCP   2'h2
`define CHG_SUSPEND   2'h3

// Register offsets (byte addresses).
`define REG_PINFN_LO  12'h000
`define REG_PINFN_HI  12'h004
`define REG_CHGMAP    12'h008
`define REG_USBSTATE  12'h00c
`define REG_STATUS    12'h010
`define REG_TOUCHMAP  12'h014

// Reset values.
`define PINFN_RST     32'h0000_0000
`define CHGMAP_RST    8'he4
`define TOUCHMAP_RST  32'h0000_0000

// Field positions in the USB state register.
`define US_CONFIGURED 0
`define US_SUSPEND    1
`define US_TX_ACT     2
`define US_RX_ACT     3
`define US_CHG_LSB    4

`endif

// ### hdl/gpio_function_status_outputs.v
// Behaviour
// - Power switch pin low when configured and not suspended
// - Power switch pin high unconfigured or suspended
// - Transmit LED lit during transmit
// - Receive LED lit during receive
// - Combined LED lit during either traffic
// - Default map: unconfigured 00, SDP 01
// - Default map: CDP/DCP 10, suspend 11
// - Charger code map is programmable
// - Up to five touch button inputs
// - Touch output pins encode pressed button
// - D+ pull-up follows sensed VBUS
// - All pins high-impedance during reset
// - Any function assignable to any pin
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "gpio_func_consts.vh"

module gpio_function_status_outputs #(
    parameter NPIN = 10
) (
    // APB slave.
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // General-purpose pins.
    input  wire [NPIN-1:0] gpio_in,
    output reg  [NPIN-1:0] gpio_out,
    output reg  [NPIN-1:0] gpio_oe,
    // USB core status.
    input  wire        usb_configured,
    input  wire        usb_suspend,
    input  wire        usb_tx_active,
    input  wire        usb_rx_active,
    input  wire [1:0]  charger_state,
    // USB D+ pull-up control.
    output reg         dp_pullup_en
);

    ////////////////////////////////////////////////////////////////////////////
    // Register file.

    reg  [4*16-1:0] pinfn_r;
    reg  [7:0]      chgmap_r;
    reg  [31:0]     touchmap_r;
    reg  [4:0]      touch_r;
    reg             vbus_r;
    reg  [2:0]      code_r;

    wire wr_en = psel & penable & pwrite;
    wire rd_ok = (paddr == `REG_PINFN_LO) | (paddr == `REG_PINFN_HI) |
                 (paddr == `REG_CHGMAP) | (paddr == `REG_USBSTATE) |
                 (paddr == `REG_STATUS) | (paddr == `REG_TOUCHMAP);

    // Zero wait states keeps the slave simple; every access ends in its first access cycle.
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~rd_ok;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pinfn_r    <= {2{`PINFN_RST}};
            chgmap_r   <= `CHGMAP_RST;
            touchmap_r <= `TOUCHMAP_RST;
        end else if (wr_en) begin
            if (paddr == `REG_PINFN_LO)
                pinfn_r[31:0] <= pwdata;
            if (paddr == `REG_PINFN_HI)
                pinfn_r[63:32] <= pwdata;
            if (paddr == `REG_CHGMAP)
                chgmap_r <= pwdata[7:0];
            if (paddr == `REG_TOUCHMAP)
                touchmap_r <= pwdata;
        end
    end

    // Read data is captured in the setup cycle, so it stands through the whole access phase.
    reg  [31:0]     rdata_nxt;

    always @* begin
        rdata_nxt = 32'h0000_0000;
        case (paddr)
            `REG_PINFN_LO: rdata_nxt = pinfn_r[31:0];
            `REG_PINFN_HI: rdata_nxt = pinfn_r[63:32];
            `REG_CHGMAP:   rdata_nxt = {24'h00_0000, chgmap_r};
            `REG_USBSTATE: rdata_nxt = {26'h000_0000, charger_state, usb_rx_active,
                                        usb_tx_active, usb_suspend, usb_configured};
            `REG_STATUS:   rdata_nxt = {22'h00_0000, dp_pullup_en, vbus_r, code_r, touch_r};
            `REG_TOUCHMAP: rdata_nxt = touchmap_r;
            default:       rdata_nxt = 32'h0000_0000;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            if (pwrite)
                prdata <= 32'h0000_0000;
            else
                prdata <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input sampling from pins assigned an input function.

    integer i;
    reg [2:0] tidx;
    reg [4:0] touch_nxt;
    reg       vbus_nxt;
    reg [2:0] code_nxt;

    always @* begin
        touch_nxt = 5'h00;
        vbus_nxt  = 1'b0;
        tidx      = 3'h0;
        for (i = 0; i < NPIN; i = i + 1) begin
            if (pinfn_r[4*i +: 4] == `FN_TOUCH_IN && tidx < 3'h5) begin
                touch_nxt[tidx] = gpio_in[i];
                tidx = tidx + 3'h1;
            end
            if (pinfn_r[4*i +: 4] == `FN_VBUS_SENSE)
                vbus_nxt = vbus_nxt | gpio_in[i];
        end
        // lowest pressed button wins, code is index plus one, zero for none.
        code_nxt = 3'h0;
        for (i = 4; i >= 0; i = i - 1)
            if (touch_nxt[i])
                code_nxt = i[2:0] + 3'h1;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            touch_r      <= 5'h00;
            vbus_r       <= 1'b0;
            code_r       <= 3'h0;
            dp_pullup_en <= 1'b0;
        end else begin
            touch_r      <= touch_nxt;
            vbus_r       <= vbus_nxt;
            code_r       <= code_nxt;
            dp_pullup_en <= vbus_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output pins.

    wire [1:0] chg_code = chgmap_r[2*charger_state +: 2];

    // Touch-out pins take code bits in pin order; pins past the third stay undriven.
    integer        k;
    reg [1:0]      ocnt;
    reg [NPIN-1:0] tout_bit;
    reg [NPIN-1:0] tout_ok;

    always @* begin
        tout_bit = {NPIN{1'b0}};
        tout_ok  = {NPIN{1'b0}};
        ocnt     = 2'h0;
        for (k = 0; k < NPIN; k = k + 1) begin
            if (pinfn_r[4*k +: 4] == `FN_TOUCH_OUT && ocnt != 2'h3) begin
                tout_bit[k] = code_r[ocnt];
                tout_ok[k]  = 1'b1;
                ocnt        = ocnt + 2'h1;
            end
        end
    end

    wire [NPIN-1:0] out_nxt;
    wire [NPIN-1:0] oe_nxt;

    // One decoder per pin keeps the function table in a single place.
    genvar p;
    generate
        for (p = 0; p < NPIN; p = p + 1) begin : g_pin
            pin_function_select pin_function_select_inst (
                .fn             (pinfn_r[4*p +: 4]),
                .usb_configured (usb_configured),
                .usb_suspend    (usb_suspend),
                .usb_tx_active  (usb_tx_active),
                .usb_rx_active  (usb_rx_active),
                .chg_code       (chg_code),
                .tout_bit       (tout_bit[p]),
                .tout_ok        (tout_ok[p]),
                .pin_out        (out_nxt[p]),
                .pin_oe         (oe_nxt[p])
            );
        end
    endgenerate

    // Registered pins avoid glitches on LEDs and the power switch.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_out <= {NPIN{1'b0}};
            gpio_oe  <= {NPIN{1'b0}};
        end else begin
            gpio_out <= out_nxt;
            gpio_oe  <= oe_nxt;
        end
    end

endmodule

////////////////////////////////////////////////////////////////////////////////
// One pin's function decode; the flip-flops that launch the pin live in the parent.

module pin_function_select (
    // Function code of this pin.
    input  wire [3:0] fn,
    // USB core status.
    input  wire       usb_configured,
    input  wire       usb_suspend,
    input  wire       usb_tx_active,
    input  wire       usb_rx_active,
    // Derived sources.
    input  wire [1:0] chg_code,
    input  wire       tout_bit,
    input  wire       tout_ok,
    // Pin drive.
    output reg        pin_out,
    output reg        pin_oe
);

    always @* begin
        pin_out = 1'b0;
        pin_oe  = 1'b0;
        case (fn)
            `FN_HIZ: begin
                pin_out = 1'b0;
                pin_oe  = 1'b0;
            end
            `FN_DRIVE1: begin
                pin_out = 1'b1;
                pin_oe  = 1'b1;
            end
            `FN_DRIVE0: begin
                pin_out = 1'b0;
                pin_oe  = 1'b1;
            end
            `FN_POWER_N: begin
                pin_out = ~usb_configured | usb_suspend;
                pin_oe  = 1'b1;
            end
            `FN_TX_LED_N: begin
                pin_out = ~usb_tx_active;
                pin_oe  = 1'b1;
            end
            `FN_RX_LED_N: begin
                pin_out = ~usb_rx_active;
                pin_oe  = 1'b1;
            end
            `FN_ANY_LED_N: begin
                pin_out = ~(usb_tx_active | usb_rx_active);
                pin_oe  = 1'b1;
            end
            `FN_CHG_BIT0: begin
                pin_out = chg_code[0];
                pin_oe  = 1'b1;
            end
            `FN_CHG_BIT1: begin
                pin_out = chg_code[1];
                pin_oe  = 1'b1;
            end
            // Input functions leave the pin undriven so the pad level can be read.
            `FN_VBUS_SENSE, `FN_TOUCH_IN: begin
                pin_out = 1'b0;
                pin_oe  = 1'b0;
            end
            `FN_TOUCH_OUT: begin
                pin_out = tout_bit;
                pin_oe  = tout_ok;
            end
            default: begin
                pin_out = 1'b0;
                pin_oe  = 1'b0;
            end
        endcase
    end

endmodule

// ### test/gpio_function_status_outputs_properties.sv
`timescale 1ns/1ps
`include "gpio_func_consts.vh"
module gpio_props #(parameter NPIN = 10) (
    // Bus side.
    input wire            pclk,
    input wire            presetn,
    input wire            psel,
    input wire            penable,
    input wire            pwrite,
    input wire [11:0]     paddr,
    input wire [31:0]     pwdata,
    input wire [31:0]     prdata,
    input wire            pready,
    input wire            pslverr,
    // Pins.
    input wire [NPIN-1:0] gpio_in,
    input wire [NPIN-1:0] gpio_out,
    input wire [NPIN-1:0] gpio_oe,
    // USB status.
    input wire            usb_configured,
    input wire            usb_suspend,
    input wire            usb_tx_active,
    input wire            usb_rx_active,
    input wire [1:0]      charger_state,
    input wire            dp_pullup_en
);
    // The function register is hidden, so the low pin word is shadowed from bus writes.
    reg [31:0] fnlo_r;
    always @(posedge pclk or negedge presetn)
        if (!presetn) fnlo_r <= 32'h0000_0000;
        else if (psel && penable && pwrite && paddr == `REG_PINFN_LO) fnlo_r <= pwdata;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_RST_HIZ: assert property ($rose(presetn) |-> gpio_oe == 0)
        else $error("pins driven at reset");
    AST_HIZ: assert property ($past(fnlo_r[3:0]) == `FN_HIZ |-> !gpio_oe[0])
        else $error("hiz pin driven");
    AST_DRV1: assert property ($past(fnlo_r[7:4]) == `FN_DRIVE1 |->
        gpio_oe[1] && gpio_out[1]) else $error("drive1 wrong");
    AST_DRV0: assert property ($past(fnlo_r[11:8]) == `FN_DRIVE0 |->
        gpio_oe[2] && !gpio_out[2]) else $error("drive0 wrong");
    AST_PWR: assert property ($past(fnlo_r[3:0]) == `FN_POWER_N |->
        gpio_out[0] == ($past(usb_suspend) || !$past(usb_configured))) else $error("power");
    AST_TX: assert property ($past(fnlo_r[7:4]) == `FN_TX_LED_N |->
        gpio_out[1] == !$past(usb_tx_active)) else $error("tx led");
    AST_RX: assert property ($past(fnlo_r[11:8]) == `FN_RX_LED_N |->
        gpio_out[2] == !$past(usb_rx_active)) else $error("rx led");
    AST_ANY: assert property ($past(fnlo_r[15:12]) == `FN_ANY_LED_N |->
        gpio_out[3] == !($past(usb_tx_active) || $past(usb_rx_active))) else $error("any led");
    AST_SLVERR: assert property (psel && penable && paddr > 12'h014 |-> pslverr && prdata == 0)
        else $error("unmapped access");
    cover property ($past(fnlo_r[3:0]) == `FN_POWER_N && $past(usb_configured));
    cover property ($past(fnlo_r[15:12]) == `FN_ANY_LED_N && !gpio_out[3]);
    cover property (psel && penable && pslverr);
endmodule
bind gpio_function_status_outputs gpio_props #(.NPIN(NPIN)) gpio_props_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .usb_configured(usb_configured), .usb_suspend(usb_suspend),
    .usb_tx_active(usb_tx_active), .usb_rx_active(usb_rx_active),
    .charger_state(charger_state), .dp_pullup_en(dp_pullup_en));

// ### test/pin_world.sv
`timescale 1ns/1ps
module pin_world #(parameter NPIN = 10) (
    // Device drive.
    input  wire [NPIN-1:0] gpio_out,
    input  wire [NPIN-1:0] gpio_oe,
    // VBUS divider and touch pads.
    input  wire [NPIN-1:0] src_val,
    input  wire [NPIN-1:0] src_en,
    // Pad level.
    output wire [NPIN-1:0] pad
);
    // Weak pull-ups: a pad nobody drives reads high, never a stale value.
    assign pad = (gpio_oe & gpio_out) | (~gpio_oe & (~src_en | src_val));
endmodule

// ### test/tb_gpio_function_status_outputs.sv
`timescale 1ns/1ps
`include "gpio_func_consts.vh"
module tb_gpio_function_status_outputs;
    reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    reg  [11:0] paddr = 0;
    reg  [31:0] pwdata = 0, rd;
    reg         usb_configured = 0, usb_suspend = 0, usb_tx_active = 0, usb_rx_active = 0;
    reg  [1:0]  charger_state = 0;
    reg  [9:0]  src_val = 0, src_en = 0;
    wire [31:0] prdata;
    wire        pready, pslverr, dp_pullup_en;
    wire [9:0]  gpio_in, gpio_out, gpio_oe;
    integer     n_errors = 0, checks_done = 0, cyc = 0, i;
    gpio_function_status_outputs #(.NPIN(10)) gpio_function_status_outputs_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .usb_configured(usb_configured), .usb_suspend(usb_suspend),
        .usb_tx_active(usb_tx_active), .usb_rx_active(usb_rx_active),
        .charger_state(charger_state), .dp_pullup_en(dp_pullup_en));
    pin_world #(.NPIN(10)) pin_world_inst (.gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .src_val(src_val), .src_en(src_en), .pad(gpio_in));
    initial forever #50 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors = n_errors + 1;
            finish_test;
        end
    end
    task finish_test;
        begin
            $display("errors %0d checks %0d", n_errors, checks_done);
            if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("CHECK FAILED %0s exp %h got %h", what, exp, got);
            end
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task wt(input integer n);
        begin
            repeat (n) @(posedge pclk);
            #1;
        end
    endtask
    task t_reset;
        begin
            repeat (8) @(posedge pclk);
            chk("rst oe", 10'h000, gpio_oe);
            chk("rst pads", 10'h3ff, gpio_in);
            presetn <= 1'b1;
            apb(0, `REG_CHGMAP, 32'h0);
            chk("chgmap", 32'h0000_00e4, rd);
        end
    endtask
    task t_static;
        begin
            apb(1, `REG_PINFN_LO, 32'h0000_0210);
            wt(2);
            chk("oe", 10'h006, gpio_oe);
            chk("out", 10'h002, gpio_out & 10'h006);
            @(posedge pclk);
            presetn <= 1'b0;
            wt(1);
            chk("mid rst oe", 10'h000, gpio_oe);
            @(posedge pclk);
            presetn <= 1'b1;
        end
    endtask
    task t_usb;
        begin
            apb(1, `REG_PINFN_LO, 32'h0000_6543);
            apb(1, `REG_PINFN_HI, 32'h0000_0087);
            for (i = 0; i < 32; i = i + 1) begin
                if (i == 16) apb(1, `REG_CHGMAP, 32'h0000_001b);
                @(posedge pclk);
                {usb_rx_active, usb_tx_active, usb_suspend, usb_configured} <= i[3:0];
                charger_state <= i[1:0];
                wt(2);
                chk("power", i[1] | !i[0], gpio_out[0]);
                chk("leds", {~|i[3:2], ~i[3], ~i[2]}, gpio_out[3:1]);
                chk("charger", i[1:0] ^ {2{i[4]}}, {gpio_out[9], gpio_out[8]});
            end
            chk("usb oe", 10'h30f, gpio_oe);
            apb(0, `REG_USBSTATE, 32'h0);
            chk("usbstate", 32'h0000_003f, rd);
        end
    endtask
    task t_sense;
        begin
            apb(1, `REG_PINFN_LO, 32'hbaa9_0000);
            apb(1, `REG_PINFN_HI, 32'h0000_000b);
            @(posedge pclk);
            src_en <= 10'h070;
            src_val <= 10'h050;
            wt(4);
            chk("pullup", 1, dp_pullup_en);
            chk("code", 2, {gpio_out[8], gpio_out[7]});
            @(posedge pclk);
            src_val <= 10'h020;
            wt(4);
            chk("pullup", 0, dp_pullup_en);
            chk("code", 1, {gpio_out[8], gpio_out[7]});
            @(posedge pclk);
            src_val <= 10'h060;
            wt(4);
            chk("code both", 1, {gpio_out[8], gpio_out[7]});
            apb(0, `REG_STATUS, 32'h0);
            chk("status", 32'h0000_0023, rd);
            apb(0, `REG_PINFN_LO, 32'h0);
            chk("pinfn lo", 32'hbaa9_0000, rd);
        end
    endtask
    task t_apb;
        begin
            apb(1, 12'h020, 32'hffff_ffff);
            apb(0, 12'h020, 32'h0);
            chk("slverr", 1, err);
            chk("unmapped", 0, rd);
            apb(1, `REG_TOUCHMAP, 32'h1234_5678);
            apb(0, `REG_TOUCHMAP, 32'h0);
            chk("scratch", 32'h1234_5678, rd);
            chk("scratch err", 0, err);
        end
    endtask
    initial begin
        t_reset;
        t_static;
        t_usb;
        t_sense;
        t_apb;
        finish_test;
    end
endmodule
